// >>> hdl/aca_pkg.sv
// Overview of operation
// [RULE1] Every channel has high-high, high, low and low-low process alarm limits.
// [RULE2] Process alarms stay disabled after reset until the controller enables them.
// [RULE3] An enabled channel reaching a limit sets that alarm status bit.
// [RULE4] Limits are compared with the scaled value in engineering units.
// [RULE5] A per-channel latch bit keeps triggered process alarms set until unlatched.
// [RULE6] A latched process alarm clears only by an unlatch request; the code also clears it while the channel's alarm_enable bit is 0.
// [RULE7] Each process alarm has its own release bit; a 0-to-1 edge clears it.
// [RULE8] Release is edge based; a release bit held at 1 does not clear again.
// [RULE9] The controller returns each release bit to 0 after unlatching.
// [RULE10] The controller unlatches only after the alarm condition has gone.
// [RULE11] Without latching, an alarm clears when its condition ends, after deadband.
// [RULE12] The deadband holds an alarm while the value stays within it of the limit.
// [RULE13] Sample-to-sample change above the rate limit sets the rate alarm status.
// [RULE14] Rate alarm latching is selected per channel.
// [RULE15] A rising rate release bit clears a latched rate alarm.
// [RULE16] Unlatching while the rate is still excessive relatches at once.
// [RULE17] The controller unlatches the rate alarm only once the rate is back in limit.
// [RULE18] A per-channel sensor offset is added to each sample value.
// [RULE19] The controller supplies the offset through the channel offset value.
// [RULE20] Wire-break detection acts only when its per-channel enable is set.
// [RULE21] Current mode open wire forces underrange data and sets wire-break and fault.
// [RULE22] Alarms are judged once per sample after the offset; reset clears them.
package aca_pkg;

	// ----------------------------------------------------------------
	// Sizes and reset values
	// ----------------------------------------------------------------
	localparam int NUM_CH   = 8;
	localparam int CH_W     = 3;
	localparam int NUM_PROC = 4;

	typedef logic signed [15:0] aca_data_t;
	typedef logic        [15:0] aca_rate_t;
	typedef logic   [CH_W-1:0]  aca_chan_t;
	typedef logic [NUM_CH-1:0]  aca_mask_t;

	localparam aca_mask_t MASK_RST = 8'h00;
	localparam aca_data_t DATA_RST = 16'h0000;
	localparam aca_chan_t CHAN_RST = 3'h0;

	// Process alarm slot positions.
	localparam int IDX_HH = 0;
	localparam int IDX_H  = 1;
	localparam int IDX_L  = 2;
	localparam int IDX_LL = 3;

	// Current below which a current loop counts as open; the converter flags it.
	localparam int OPEN_WIRE_MIN_UA = 100;
	// Clock edges from a sample strobe to its result on the outputs.
	localparam int EVAL_LATENCY = 2;

	// ----------------------------------------------------------------
	// Saturating arithmetic
	// ----------------------------------------------------------------
	function automatic aca_data_t aca_sat(input logic signed [16:0] s);
		if (s[16] != s[15]) begin
			return s[16] ? 16'h8000 : 16'h7FFF;
		end
		return s[15:0];
	endfunction

	function automatic aca_data_t aca_sat_add(input aca_data_t a, input aca_data_t b);
		return aca_sat({a[15], a} + {b[15], b});
	endfunction

	function automatic aca_data_t aca_sat_sub(input aca_data_t a, input aca_data_t b);
		return aca_sat({a[15], a} - {b[15], b});
	endfunction

endpackage

// >>> hdl/aca_limit_cmp.sv
`timescale 1ns/1ps
module aca_limit_cmp #(
	parameter bit IS_HIGH = 1'b1
) (
	input  wire aca_pkg::aca_data_t value,
	input  wire aca_pkg::aca_data_t limit,
	input  wire aca_pkg::aca_data_t deadband,
	input  wire logic               alarm_now,
	output logic                    trig,
	output logic                    cond
);
	import aca_pkg::*;

	aca_data_t edge_val;
	logic      hold;

	// Trigger on reaching the limit; hold inside the deadband band on the normal side of it.
	always_comb begin
		edge_val = IS_HIGH ? aca_sat_sub(limit, deadband) : aca_sat_add(limit, deadband);
		trig     = IS_HIGH ? (value >= limit) : (value <= limit); // RULE3 RULE4
		hold     = IS_HIGH ? (value > edge_val) : (value < edge_val); // RULE12
		cond     = trig | (alarm_now & hold); // RULE11
	end
endmodule

// >>> hdl/aca_alarm_top.sv
`timescale 1ns/1ps
module aca_alarm_top (
	input  wire logic                                  clk,
	input  wire logic                                  rst,
	input  wire logic                                  sample_valid,
	input  wire aca_pkg::aca_chan_t                    sample_chan,
	input  wire aca_pkg::aca_data_t                    sample_data,
	input  wire logic                                  sample_current_low,
	input  wire aca_pkg::aca_mask_t                    alarm_enable,
	input  wire aca_pkg::aca_mask_t                    proc_latch_en,
	input  wire aca_pkg::aca_mask_t                    rate_latch_en,
	input  wire aca_pkg::aca_mask_t                    open_wire_en,
	input  wire aca_pkg::aca_mask_t                    current_mode,
	input  wire aca_pkg::aca_data_t [aca_pkg::NUM_CH-1:0] hh_limit,
	input  wire aca_pkg::aca_data_t [aca_pkg::NUM_CH-1:0] high_limit,
	input  wire aca_pkg::aca_data_t [aca_pkg::NUM_CH-1:0] low_limit,
	input  wire aca_pkg::aca_data_t [aca_pkg::NUM_CH-1:0] ll_limit,
	input  wire aca_pkg::aca_data_t [aca_pkg::NUM_CH-1:0] alarm_deadband,
	input  wire aca_pkg::aca_rate_t [aca_pkg::NUM_CH-1:0] rate_limit,
	input  wire aca_pkg::aca_data_t [aca_pkg::NUM_CH-1:0] channel_offset_value,
	input  wire aca_pkg::aca_data_t [aca_pkg::NUM_CH-1:0] underrange_value,
	input  wire aca_pkg::aca_mask_t                    hh_alarm_release_bit,
	input  wire aca_pkg::aca_mask_t                    high_alarm_release_bit,
	input  wire aca_pkg::aca_mask_t                    low_alarm_release_bit,
	input  wire aca_pkg::aca_mask_t                    ll_alarm_release_bit,
	input  wire aca_pkg::aca_mask_t                    rate_alarm_release_bit,
	output aca_pkg::aca_mask_t                         hh_alarm_status,
	output aca_pkg::aca_mask_t                         high_alarm_status,
	output aca_pkg::aca_mask_t                         low_alarm_status,
	output aca_pkg::aca_mask_t                         ll_alarm_status,
	output aca_pkg::aca_mask_t                         rate_alarm_status,
	output aca_pkg::aca_mask_t                         wire_break_status,
	output aca_pkg::aca_mask_t                         channel_fault_status,
	output logic                                       data_valid,
	output aca_pkg::aca_chan_t                         data_chan,
	output aca_pkg::aca_data_t                         data_value
);
	import aca_pkg::*;
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	aca_mask_t                 alarm_en_reg;
	aca_mask_t [NUM_PROC-1:0]  proc_status_reg;
	aca_mask_t [NUM_PROC-1:0]  rel_prev_reg;
	aca_mask_t [NUM_PROC-1:0]  rel_in;
	aca_mask_t [NUM_PROC-1:0]  rel_rise;
	aca_mask_t                 rate_prev_reg;
	aca_mask_t                 rate_rise;
	aca_mask_t                 rate_status_reg;
	aca_mask_t                 rate_exceed_reg;
	aca_mask_t                 prev_valid_reg;
	aca_data_t                 prev_reg [NUM_CH];
	aca_mask_t                 wire_reg;
	aca_mask_t                 fault_reg;
	logic                      s1_valid_reg;
	aca_chan_t                 s1_chan_reg;
	aca_data_t                 s1_value_reg;
	logic                      s1_open_reg;
	logic                      out_valid_reg;
	aca_chan_t                 out_chan_reg;
	aca_data_t                 out_value_reg;
	logic                      open_now;
	aca_data_t                 s1_value_next;
	aca_data_t                 lim [NUM_PROC];
	logic      [NUM_PROC-1:0]  trig;
	logic      [NUM_PROC-1:0]  cond;
	logic signed [16:0]        diff;
	logic        [16:0]        diff_abs;
	logic                      rate_over;

	// ----------------------------------------------------------------
	// Stage one: offset and open wire substitution
	// ----------------------------------------------------------------
	// Open wire only counts in current mode with detection enabled.
	always_comb begin
		open_now = sample_current_low & open_wire_en[sample_chan]
			& current_mode[sample_chan]; // RULE20 RULE21
		s1_value_next = open_now ? underrange_value[sample_chan]
			: aca_sat_add(sample_data, channel_offset_value[sample_chan]); // RULE18 RULE21
	end
	// Saturation keeps a large offset from wrapping a value across the limits.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_valid_reg <= 1'b0;
			s1_chan_reg  <= CHAN_RST;
			s1_value_reg <= DATA_RST;
			s1_open_reg  <= 1'b0;
		end else begin
			s1_valid_reg <= sample_valid;
			s1_chan_reg  <= sample_chan;
			s1_value_reg <= s1_value_next;
			s1_open_reg  <= open_now;
		end
	end
	// ----------------------------------------------------------------
	// Stage two: process alarm comparators
	// ----------------------------------------------------------------
	always_comb begin
		lim[IDX_HH] = hh_limit[s1_chan_reg];
		lim[IDX_H]  = high_limit[s1_chan_reg];
		lim[IDX_L]  = low_limit[s1_chan_reg];
		lim[IDX_LL] = ll_limit[s1_chan_reg];
	end
	for (genvar k = 0; k < NUM_PROC; k++) begin : g_cmp
		aca_limit_cmp #(
			.IS_HIGH ((k == IDX_HH) || (k == IDX_H))
		) u_cmp (
			.value     (s1_value_reg),
			.limit     (lim[k]),
			.deadband  (alarm_deadband[s1_chan_reg]),
			.alarm_now (proc_status_reg[k][s1_chan_reg]),
			.trig      (trig[k]),
			.cond      (cond[k])
		); // RULE1
	end
	// Release bits from the controller come from the same clock; no sync needed.
	always_comb begin
		rel_in[IDX_HH] = hh_alarm_release_bit;
		rel_in[IDX_H]  = high_alarm_release_bit;
		rel_in[IDX_L]  = low_alarm_release_bit;
		rel_in[IDX_LL] = ll_alarm_release_bit;
		for (int k = 0; k < NUM_PROC; k++) begin
			rel_rise[k] = rel_in[k] & ~rel_prev_reg[k]; // RULE7 RULE8
		end
		rate_rise = rate_alarm_release_bit & ~rate_prev_reg; // RULE15
	end
	// Enables are captured so nothing alarms until the controller enables it.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			alarm_en_reg  <= MASK_RST; // RULE2
			rel_prev_reg  <= '0;
			rate_prev_reg <= MASK_RST;
		end else begin
			alarm_en_reg  <= alarm_enable;
			rel_prev_reg  <= rel_in;
			rate_prev_reg <= rate_alarm_release_bit;
		end
	end
	// Process alarm status; a sample setting a bit wins over a release edge.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			proc_status_reg <= '0; // RULE22
		end else begin
			for (int k = 0; k < NUM_PROC; k++) begin
				for (int c = 0; c < NUM_CH; c++) begin
					if (!alarm_en_reg[c]) begin
						proc_status_reg[k][c] <= 1'b0; // RULE2
					end else if (s1_valid_reg && s1_chan_reg == aca_chan_t'(c)) begin
						if (proc_latch_en[c]) begin
							proc_status_reg[k][c] <= trig[k]
								| (proc_status_reg[k][c] & ~rel_rise[k][c]); // RULE5 RULE6
						end else begin
							proc_status_reg[k][c] <= cond[k]; // RULE11 RULE12
						end
					end else if (rel_rise[k][c] && proc_latch_en[c]) begin
						proc_status_reg[k][c] <= 1'b0; // RULE7
					end
				end
			end
		end
	end
	// ----------------------------------------------------------------
	// Rate of change
	// ----------------------------------------------------------------
	// The first sample after reset has no predecessor and never trips the rate check.
	always_comb begin
		diff      = {s1_value_reg[15], s1_value_reg}
			- {prev_reg[s1_chan_reg][15], prev_reg[s1_chan_reg]};
		diff_abs  = diff[16] ? 17'(-diff) : 17'(diff);
		rate_over = prev_valid_reg[s1_chan_reg]
			&& (diff_abs > {1'b0, rate_limit[s1_chan_reg]}); // RULE13
	end
	// Previous sample per channel, after offset.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prev_valid_reg <= MASK_RST;
			for (int c = 0; c < NUM_CH; c++) begin
				prev_reg[c] <= DATA_RST;
			end
		end else if (s1_valid_reg) begin
			prev_valid_reg[s1_chan_reg] <= 1'b1;
			prev_reg[s1_chan_reg]       <= s1_value_reg;
		end
	end
	// Rate status; a release while the rate is still high relatches at once.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rate_status_reg <= MASK_RST;
			rate_exceed_reg <= MASK_RST;
		end else begin
			for (int c = 0; c < NUM_CH; c++) begin
				if (s1_valid_reg && s1_chan_reg == aca_chan_t'(c)) begin
					rate_exceed_reg[c] <= rate_over;
				end
				if (!alarm_en_reg[c]) begin
					rate_status_reg[c] <= 1'b0;
				end else if (s1_valid_reg && s1_chan_reg == aca_chan_t'(c)) begin
					if (rate_latch_en[c]) begin
						rate_status_reg[c] <= rate_over
							| (rate_status_reg[c] & ~rate_rise[c]); // RULE14
					end else begin
						rate_status_reg[c] <= rate_over; // RULE13
					end
				end else if (rate_rise[c] && rate_latch_en[c]) begin
					rate_status_reg[c] <= rate_exceed_reg[c]; // RULE15 RULE16
				end
			end
		end
	end
	// ----------------------------------------------------------------
	// Wire break, fault and data outputs
	// ----------------------------------------------------------------
	// Wire break is not an alarm, so the alarm enable does not mask it.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wire_reg      <= MASK_RST;
			fault_reg     <= MASK_RST;
			out_valid_reg <= 1'b0;
			out_chan_reg  <= CHAN_RST;
			out_value_reg <= DATA_RST;
		end else begin
			out_valid_reg <= s1_valid_reg;
			if (s1_valid_reg) begin
				wire_reg[s1_chan_reg]  <= s1_open_reg; // RULE21
				fault_reg[s1_chan_reg] <= s1_open_reg; // RULE21
				out_chan_reg           <= s1_chan_reg;
				out_value_reg          <= s1_value_reg;
			end
		end
	end
	// Every output is a plain copy of a register, so no logic sits after the flops.
	assign hh_alarm_status      = proc_status_reg[IDX_HH];
	assign high_alarm_status    = proc_status_reg[IDX_H];
	assign low_alarm_status     = proc_status_reg[IDX_L];
	assign ll_alarm_status      = proc_status_reg[IDX_LL];
	assign rate_alarm_status    = rate_status_reg;
	assign wire_break_status    = wire_reg;
	assign channel_fault_status = fault_reg;
	assign data_valid           = out_valid_reg;
	assign data_chan            = out_chan_reg;
	assign data_value           = out_value_reg;
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_disabled_quiet;
		(alarm_enable == 8'h00) ##1 (alarm_enable == 8'h00) |=> (proc_status_reg == '0);
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet) else $error("alarm while disabled"); // RULE2
	property p_latency;
		sample_valid |-> ##2 data_valid;
	endproperty
	a_latency: assert property (p_latency) else $error("sample result late"); // RULE22
	property p_offset;
		sample_valid && !open_now |=> s1_value_reg
			== aca_sat_add($past(sample_data), $past(channel_offset_value[sample_chan]));
	endproperty
	a_offset: assert property (p_offset) else $error("offset not applied"); // RULE18
	property p_open_wire;
		s1_valid_reg && s1_open_reg |=> wire_break_status[$past(s1_chan_reg)]
			&& channel_fault_status[$past(s1_chan_reg)]
			&& data_value == $past(s1_value_reg);
	endproperty
	a_open_wire: assert property (p_open_wire) else $error("open wire not flagged"); // RULE21
	property p_latched_hold;
		alarm_en_reg[1] && alarm_enable[1] && proc_latch_en[1]
			&& proc_status_reg[IDX_H][1] && !rel_rise[IDX_H][1] |=> proc_status_reg[IDX_H][1];
	endproperty
	a_latched_hold: assert property (p_latched_hold) else $error("latched alarm dropped"); // RULE6
	property p_release_edge;
		rel_rise[IDX_L][1] && proc_latch_en[1] && !(s1_valid_reg && s1_chan_reg == 3'h1)
			|=> !proc_status_reg[IDX_L][1];
	endproperty
	a_release_edge: assert property (p_release_edge) else $error("release edge ignored"); // RULE7
	property p_level_release;
		alarm_en_reg[1] && alarm_enable[1] && proc_latch_en[1] && rel_in[IDX_H][1]
			&& rel_prev_reg[IDX_H][1] && proc_status_reg[IDX_H][1] |=> proc_status_reg[IDX_H][1];
	endproperty
	a_level_release: assert property (p_level_release) else $error("level cleared alarm"); // RULE8
	property p_rate_set;
		s1_valid_reg && rate_over && alarm_en_reg[s1_chan_reg] && alarm_enable[s1_chan_reg]
			|=> rate_alarm_status[$past(s1_chan_reg)];
	endproperty
	a_rate_set: assert property (p_rate_set) else $error("rate alarm missed"); // RULE13
	property p_rate_relatch;
		rate_rise[1] && rate_latch_en[1] && rate_exceed_reg[1] && alarm_en_reg[1]
			&& !(s1_valid_reg && s1_chan_reg == 3'h1) |=> rate_alarm_status[1];
	endproperty
	a_rate_relatch: assert property (p_rate_relatch) else $error("rate not relatched"); // RULE16
	property p_unlatched_clear;
		s1_valid_reg && s1_chan_reg == 3'h0 && alarm_en_reg[0] && !proc_latch_en[0]
			&& !cond[IDX_HH] |=> !hh_alarm_status[0];
	endproperty
	a_unlatched_clear: assert property (p_unlatched_clear) else $error("alarm not cleared"); // RULE11
	c_latched: cover property (proc_latch_en[1] && rel_rise[IDX_H][1] && proc_status_reg[IDX_H][1]);
	c_rate: cover property (s1_valid_reg && rate_over);
	c_open: cover property (s1_valid_reg && s1_open_reg);
	c_deadband: cover property (s1_valid_reg && cond[IDX_LL] && !trig[IDX_LL]);
endmodule

// >>> verification/aca_ctrl_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Controller model: owns the release bits and the sensor offsets
// ----------------------------------------------------------------
module aca_ctrl_model (
	input  wire logic                               clk,
	input  wire logic                               rst,
	input  wire logic                               go,
	input  wire logic [2:0]                         kind,
	input  wire aca_pkg::aca_chan_t                 chan,
	input  wire logic                               hold,
	input  wire logic                               slow,
	output aca_pkg::aca_mask_t [4:0]                rel,
	output aca_pkg::aca_data_t [aca_pkg::NUM_CH-1:0] offs
);
	import aca_pkg::*;

	logic [2:0] cnt_reg;

	// A release is a pulse that returns to zero; slow stretches it, hold leaves it high.
	// Only one release is outstanding at a time, so clearing all bits is safe.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rel     <= '0;
			cnt_reg <= 3'h0;
		end else if (go) begin
			rel[kind][chan] <= 1'b1;
			cnt_reg         <= slow ? 3'h4 : 3'h1;
		end else if (cnt_reg != 3'h0) begin
			cnt_reg <= cnt_reg - 3'h1;
		end else if (!hold) begin
			rel <= '0;
		end
	end

	// Fixed offsets spread around zero, so both signs are exercised.
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			offs[i] = aca_data_t'(i - 3);
		end
	end
endmodule

// >>> verification/testbench.sv
`timescale 1ns/1ps
module testbench;
	import aca_pkg::*;

	// ----------------------------------------------------------------
	// Signals and reference state
	// ----------------------------------------------------------------
	localparam int DBV = 5;
	localparam int RLV = 30;
	logic                   clk, rst, sample_valid, sample_current_low, go, hold, slow;
	aca_chan_t              sample_chan, chan_r, data_chan;
	aca_data_t              sample_data, data_value;
	logic [2:0]             kind;
	logic                   data_valid;
	aca_mask_t              alarm_enable, proc_latch_en, rate_latch_en, open_wire_en, current_mode;
	aca_data_t [NUM_CH-1:0] hh_limit, high_limit, low_limit, ll_limit, alarm_deadband;
	aca_data_t [NUM_CH-1:0] channel_offset_value, underrange_value;
	aca_rate_t [NUM_CH-1:0] rate_limit;
	aca_mask_t [4:0]        rel;
	aca_mask_t              hh_alarm_status, high_alarm_status, low_alarm_status, ll_alarm_status;
	aca_mask_t              rate_alarm_status, wire_break_status, channel_fault_status;
	bit                     st[4][NUM_CH];
	bit                     rt[NUM_CH], exc[NUM_CH], hasp[NUM_CH], owv[NUM_CH];
	int                     prv[NUM_CH];
	int                     lim[4] = '{40, 20, -20, -40};
	int                     tv[4] = '{43, 23, -23, -43};
	int                     tab[13] = '{0, 23, 19, 18, -17, -13, -12, 43, 39, 38, -37, -33, -32};
	logic [25:0]            exq[$];
	int                     err_total, cmp_count;

	aca_alarm_top i_dut (.clk, .rst, .sample_valid, .sample_chan, .sample_data,
		.sample_current_low, .alarm_enable, .proc_latch_en, .rate_latch_en, .open_wire_en,
		.current_mode, .hh_limit, .high_limit, .low_limit, .ll_limit, .alarm_deadband,
		.rate_limit, .channel_offset_value, .underrange_value,
		.hh_alarm_release_bit(rel[0]), .high_alarm_release_bit(rel[1]),
		.low_alarm_release_bit(rel[2]), .ll_alarm_release_bit(rel[3]),
		.rate_alarm_release_bit(rel[4]), .hh_alarm_status, .high_alarm_status,
		.low_alarm_status, .ll_alarm_status, .rate_alarm_status, .wire_break_status,
		.channel_fault_status, .data_valid, .data_chan, .data_value);

	aca_ctrl_model i_ctrl (.clk, .rst, .go, .kind, .chan(chan_r), .hold, .slow, .rel,
		.offs(channel_offset_value));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [6:0] exp7(int c);
		return {st[0][c], st[1][c], st[2][c], st[3][c], rt[c], owv[c], owv[c]};
	endfunction

	function automatic logic [6:0] seen7(int c);
		return {hh_alarm_status[c], high_alarm_status[c], low_alarm_status[c],
			ll_alarm_status[c], rate_alarm_status[c], wire_break_status[c],
			channel_fault_status[c]};
	endfunction

	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Drives one sample and notes its expected result; the strobe is left high for
	// back-to-back use, idle() lowers it.
	task automatic smp(int c, int d, bit low);
		int v;
		bit hi, tr, hd;
		owv[c] = open_wire_en[c] && current_mode[c] && low;
		v = owv[c] ? int'(signed'(underrange_value[c])) : d + int'(signed'(channel_offset_value[c]));
		v = v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
		for (int k = 0; k < 4; k++) begin
			hi = k < 2;
			tr = hi ? v >= lim[k] : v <= lim[k];
			hd = hi ? v > lim[k] - DBV : v < lim[k] + DBV;
			st[k][c] = alarm_enable[c] && (tr || (st[k][c] && (proc_latch_en[c] || hd)));
		end
		exc[c] = hasp[c] && (v - prv[c] > RLV || prv[c] - v > RLV);
		rt[c] = alarm_enable[c] && (exc[c] || (rt[c] && rate_latch_en[c]));
		prv[c] = v;
		hasp[c] = 1'b1;
		exq.push_back({3'(c), 16'(v), exp7(c)});
		sample_valid <= 1'b1;
		sample_chan <= 3'(c);
		sample_data <= 16'(d);
		sample_current_low <= low;
		@(posedge clk);
	endtask

	task automatic idle(int n);
		sample_valid <= 1'b0;
		repeat (n) @(posedge clk);
	endtask

	// Bounded wait until every noted result has been seen.
	task automatic drain();
		idle(3);
		for (int i = 0; i < 40 && exq.size() != 0; i++) @(posedge clk);
		if (exq.size() != 0) begin
			err_total++;
			close_out();
		end
	endtask

	// Asks the controller model for a release and notes its effect; ends at a falling edge.
	task automatic rls(int k, int c, bit h, bit s);
		if (k < 4 && proc_latch_en[c]) st[k][c] = 1'b0;
		if (k == 4 && rate_latch_en[c]) rt[c] = exc[c];
		go <= 1'b1;
		kind <= 3'(k);
		chan_r <= 3'(c);
		hold <= h;
		slow <= s;
		@(posedge clk);
		go <= 1'b0;
		repeat (8) @(posedge clk);
		@(negedge clk);
	endtask

	// ----------------------------------------------------------------
	// Clock, watchdog and result monitor
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		#1000000;
		err_total++;
		close_out();
	end

	// Outputs are read at the falling edge, where the pipeline has settled.
	always @(negedge clk) begin
		if (data_valid === 1'b1) begin
			if (exq.size() == 0) chk(32'h0000_0001, 32'h0000_0000);
			else chk({data_chan, data_value, seen7(int'(data_chan))}, exq.pop_front());
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{rst, go, hold, slow, sample_valid, sample_current_low} = 6'b10_0000;
		{kind, chan_r, sample_chan, sample_data} = '0;
		{alarm_enable, proc_latch_en, rate_latch_en} = {8'h00, 8'h52, 8'h32};
		{open_wire_en, current_mode} = {8'h04, 8'h0C};
		for (int i = 0; i < NUM_CH; i++) begin
			{hh_limit[i], high_limit[i], low_limit[i], ll_limit[i]} = {16'(lim[0]),
				16'(lim[1]), 16'(lim[2]), 16'(lim[3])};
			{alarm_deadband[i], rate_limit[i], underrange_value[i]} = {16'(DBV), 16'(RLV),
				16'hFF9C};
		end
		void'($urandom(15490));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		smp(7, 100, 0);
		smp(7, -100, 0);
		drain();
		@(negedge clk) chk(seen7(7), 7'h00);
		alarm_enable <= 8'hFF;
		idle(3);
		foreach (tab[i]) smp(0, tab[i], 0);
		drain();
		rls(1, 0, 0, 0);
		chk(seen7(0), exp7(0));
		// Each process alarm latches, survives a quiet sample, then is released.
		for (int k = 0; k < 4; k++) begin
			smp(1, tv[k], 0);
			smp(1, 0, 0);
			drain();
			rls(k, 1, 0, k % 2);
			chk(seen7(1), exp7(1));
		end
		// A release bit left high must not clear a later latch.
		smp(1, 23, 0);
		drain();
		rls(1, 1, 1, 0);
		chk(seen7(1), exp7(1));
		smp(1, 23, 0);
		smp(1, 0, 0);
		drain();
		@(negedge clk) chk(seen7(1), exp7(1));
		hold <= 1'b0;
		idle(4);
		rls(1, 1, 0, 0);
		chk(seen7(1), exp7(1));
		// Rate alarm: latch, hold over a small change, release, relatch.
		smp(1, 50, 0);
		smp(1, 52, 0);
		drain();
		rls(4, 1, 0, 0);
		chk(seen7(1), exp7(1));
		smp(1, 0, 0);
		drain();
		rls(4, 1, 0, 1);
		chk(seen7(1), exp7(1));
		// Open wire on an enabled and a disabled current channel, then recovery.
		smp(2, 10, 1);
		smp(3, 10, 1);
		smp(2, 10, 0);
		drain();
		// Random back-to-back traffic over channels 0 to 6.
		for (int n = 0; n < 150; n++) begin
			smp(int'($urandom_range(6)), int'($urandom_range(120)) - 60, $urandom_range(3) == 0);
		end
		drain();
		// Reset in mid-run clears every alarm and the stored previous samples.
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		st = '{default: '0};
		rt = '{default: '0};
		exc = '{default: '0};
		hasp = '{default: '0};
		owv = '{default: '0};
		@(negedge clk);
		chk({hh_alarm_status, high_alarm_status, low_alarm_status, ll_alarm_status}, 0);
		chk({rate_alarm_status, wire_break_status, channel_fault_status}, 0);
		idle(3);
		smp(1, 100, 0);
		drain();
		close_out();
	end
endmodule
